/* core/mahp_defines.svh */
// Purpose: constants for the station address, hash and PHY access block
// Assumes: 250 MHz clk, register index times four is the byte address
// Notes:   Behaviour list below
//
// Behaviour
// - address-high low 16 bits hold address 47..32, upper 16 reserved
// - power-on load of address-high bytes 0,1 from EEPROM 0x05,0x06
// - address-low holds 31..0; byte 0 from 0x01, top byte from 0x04
// - EEPROM 1..6 map to low bytes 0..3 then high bytes 0..1
// - address undefined until load; host writes accepted after init
// - hash index top bit picks high/low word, low five pick the bit
// - multicast accepted when selected hash bit is 1, else rejected
// - pass-all-group set accepts every multicast frame
// - hash high register holds table 63..32, low holds 31..0
// - PHY address from access bits 15..11; internal PHY is 00001
// - PHY register number from access bits 10..6
// - bit 1 set writes PHY from data register, clear reads into it
// - software sets bit 0 to start; stays set until access completes
// - data held for writes and invalid for reads until busy clears
// - data register low 16 bits carry PHY read and write values
`ifndef MAHP_DEFINES_SVH
`define MAHP_DEFINES_SVH
`define MAHP_IDX_ADDR_HIGH  6'h02
`define MAHP_IDX_ADDR_LOW   6'h03
`define MAHP_IDX_HASH_HIGH  6'h04
`define MAHP_IDX_HASH_LOW   6'h05
`define MAHP_IDX_ACCESS     6'h06
`define MAHP_IDX_DATA       6'h07
`define MAHP_IDX_CTRL       6'h10
`define MAHP_RST_ADDR_HIGH  32'h0000FFFF
`define MAHP_RST_ADDR_LOW   32'h0FFFFFFF
`define MAHP_RST_ZERO       32'h00000000
`define MAHP_EE_LOW_B0      8'h01
`define MAHP_EE_LOW_B1      8'h02
`define MAHP_EE_LOW_B2      8'h03
`define MAHP_EE_LOW_B3      8'h04
`define MAHP_EE_HIGH_B0     8'h05
`define MAHP_EE_HIGH_B1     8'h06
`define MAHP_ACC_PHY_MSB    15
`define MAHP_ACC_PHY_LSB    11
`define MAHP_ACC_REG_MSB    10
`define MAHP_ACC_REG_LSB    6
`define MAHP_ACC_WR         1
`define MAHP_ACC_BUSY       0
`define MAHP_INT_PHY_ADDR   5'h01
`define MAHP_CTRL_PASS      0
`define MAHP_CTRL_INIT      1
`define MAHP_CLK_NS         4
`define MAHP_MDC_HALF_NS    200
`define MAHP_MDC_HALF_CYC   ((`MAHP_MDC_HALF_NS+`MAHP_CLK_NS-1)/`MAHP_CLK_NS)
`define MAHP_MF_BITS        64
`define MAHP_MF_DRIVE_RD    46
`define MAHP_MF_DATA_LSB    48
`define MAHP_MF_PRE         32'hFFFFFFFF
`define MAHP_MF_ST          2'h1
`define MAHP_MF_OP_WR       2'h1
`define MAHP_MF_OP_RD       2'h2
`define MAHP_MF_TA_WR       2'h2
`define MAHP_CRC_POLY       32'hEDB88320
`define MAHP_CRC_INIT       32'hFFFFFFFF
`endif

/* core/mahp_pkg.sv */
// Purpose: shared types of the station address, hash and PHY access block
// Assumes: constants live in mahp_defines.svh
// Notes:   none
package mahp_pkg;
  typedef logic [31:0] mahp_word_t;
  typedef logic [15:0] mahp_half_t;
  typedef logic [4:0]  mahp_addr5_t;
  typedef enum logic {
    MAHP_MG_IDLE = 1'b0,
    MAHP_MG_RUN  = 1'b1
  } mahp_mgmt_state_t;
endpackage : mahp_pkg

/* core/mahp_mdio.sv */
// Purpose: clause 22 management frame engine
// Assumes: one access at a time; start only while idle
// Notes:   mdio changes after mdc falls, input sampled as mdc rises
`timescale 1ns/10ps
`include "mahp_defines.svh"
module mahp_mdio #(
  parameter int HALF_CYC = `MAHP_MDC_HALF_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // command
  input  wire logic              start,
  input  wire logic              wr,
  input  wire mahp_pkg::mahp_addr5_t phy_addr,
  input  wire mahp_pkg::mahp_addr5_t reg_addr,
  input  wire mahp_pkg::mahp_half_t  wdata,
  output logic                   busy,
  output logic                   done,
  output mahp_pkg::mahp_half_t   rdata,
  // management pins
  output logic                   mdc,
  output logic                   mdio_o,
  output logic                   mdio_oe,
  input  wire logic              mdio_i
);
  import mahp_pkg::*;

  mahp_mgmt_state_t state_ff;
  logic [63:0]      shreg_ff;
  logic [5:0]       bit_ff;
  logic [15:0]      div_ff;
  logic             wr_ff;
  logic             tick;
  logic             rise;
  logic             fall;

  assign tick = (state_ff == MAHP_MG_RUN) && (div_ff == 16'(HALF_CYC - 1));
  assign rise = tick && !mdc;
  assign fall = tick && mdc;
  assign busy = (state_ff == MAHP_MG_RUN);

  ////////////////////////////////////////////////////////////////////////
  // divider and state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff   <= 16'h0000;
      mdc      <= 1'b0;
      state_ff <= MAHP_MG_IDLE;
      bit_ff   <= 6'h00;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_ff)
        MAHP_MG_IDLE: begin
          div_ff <= 16'h0000;
          mdc    <= 1'b0;
          bit_ff <= 6'h00;
          if (start) begin
            state_ff <= MAHP_MG_RUN;
          end
        end
        MAHP_MG_RUN: begin
          div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
          if (tick) begin
            mdc <= !mdc;
          end
          if (fall) begin
            bit_ff <= bit_ff + 6'h01;
            if (bit_ff == 6'(`MAHP_MF_BITS - 1)) begin
              state_ff <= MAHP_MG_IDLE;
              done     <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame shifter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_ff <= 64'h0000000000000000;
      wr_ff    <= 1'b0;
      mdio_o   <= 1'b0;
      mdio_oe  <= 1'b0;
    end else if (start && !busy) begin
      shreg_ff <= {`MAHP_MF_PRE, `MAHP_MF_ST,
                   wr ? `MAHP_MF_OP_WR : `MAHP_MF_OP_RD,
                   phy_addr, reg_addr, `MAHP_MF_TA_WR, wdata};
      wr_ff    <= wr;
      mdio_o   <= 1'b1;
      mdio_oe  <= 1'b1;
    end else if (fall) begin
      shreg_ff <= {shreg_ff[62:0], 1'b0};
      mdio_o   <= shreg_ff[62];
      mdio_oe  <= (bit_ff != 6'(`MAHP_MF_BITS - 1)) &&
                  (wr_ff || bit_ff < 6'(`MAHP_MF_DRIVE_RD - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rise && !wr_ff && bit_ff >= 6'(`MAHP_MF_DATA_LSB)) begin
      rdata <= {rdata[14:0], mdio_i};
    end
  end
endmodule : mahp_mdio

/* core/mahp_top.sv */
// Purpose: station address, multicast hash and PHY management registers
// Assumes: classic Wishbone slave, 32-bit data, one clock
// Notes:   byte address is four times the register index
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
`include "mahp_defines.svh"
module mahp_top #(
  parameter int ADR_W    = 8,
  parameter int HALF_CYC = `MAHP_MDC_HALF_CYC
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire mahp_pkg::mahp_word_t wb_dat_i,
  output mahp_pkg::mahp_word_t    wb_dat_o,
  output logic                    wb_ack_o,
  // eeprom loader
  input  wire logic               ee_byte_valid,
  input  wire logic [7:0]         ee_byte_loc,
  input  wire logic [7:0]         ee_byte_data,
  input  wire logic               ee_init_done,
  // destination address check
  input  wire logic               dst_valid,
  input  wire logic [47:0]        dst_addr,
  output logic                    group_valid,
  output logic                    group_accept,
  // station address and status
  output logic [47:0]             station_addr,
  output logic                    init_done,
  // management pins
  output logic                    mdc,
  output logic                    mdio_o,
  output logic                    mdio_oe,
  output logic                    phy_int_sel,
  input  wire logic               mdio_int_i,
  input  wire logic               mdio_ext_i
);
  import mahp_pkg::*;

  mahp_word_t  addr_high_ff;
  mahp_word_t  addr_low_ff;
  mahp_word_t  hash_high_ff;
  mahp_word_t  hash_low_ff;
  mahp_addr5_t phy_addr_ff;
  mahp_addr5_t reg_idx_ff;
  logic        wr_not_rd_ff;
  mahp_half_t  data_ff;
  logic        pass_all_ff;
  logic        init_ff;
  logic        ack_ff;
  mahp_word_t  rdat_ff;
  logic        grp_valid_ff;
  logic        grp_accept_ff;

  logic        req;
  logic        wr_edge;
  logic [5:0]  idx;

  logic        hit_ahigh;
  logic        hit_alow;
  logic        hit_hhigh;
  logic        hit_hlow;
  logic        hit_acc;
  logic        hit_data;
  logic        hit_ctrl;

  logic        mg_busy;
  logic        mg_done;
  mahp_half_t  mg_rdata;
  logic        mg_start;
  logic        mdio_in;

  mahp_word_t  acc_word;
  mahp_word_t  rd_mux;

  logic [31:0] crc;
  logic [5:0]  hash_idx;
  logic        hash_bit;
  logic        is_group;
  mahp_word_t  wmerge_acc;
  mahp_word_t  wmerge_ahigh;
  mahp_word_t  wmerge_data;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic mahp_word_t merge(
    input mahp_word_t old_v,
    input mahp_word_t new_v,
    input logic [3:0] sel
  );
    mahp_word_t r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // reflected crc-32 over the six bytes, first wire byte in [7:0]
  function automatic logic [31:0] crc48(input logic [47:0] a);
    logic [31:0] c;
    logic        fb;
    c = `MAHP_CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      fb = c[0] ^ a[i];
      c  = {1'b0, c[31:1]};
      if (fb) begin
        c = c ^ `MAHP_CRC_POLY;
      end
    end
    return c;
  endfunction : crc48

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  // index is the word address
  assign req       = wb_cyc_i && wb_stb_i;
  assign wr_edge   = req && wb_we_i && ack_ff;
  assign idx       = wb_adr_i[7:2];
  assign hit_ahigh = (idx == `MAHP_IDX_ADDR_HIGH);
  assign hit_alow  = (idx == `MAHP_IDX_ADDR_LOW);
  assign hit_hhigh = (idx == `MAHP_IDX_HASH_HIGH);
  assign hit_hlow  = (idx == `MAHP_IDX_HASH_LOW);
  assign hit_acc   = (idx == `MAHP_IDX_ACCESS);
  assign hit_data  = (idx == `MAHP_IDX_DATA);
  assign hit_ctrl  = (idx == `MAHP_IDX_CTRL);

  assign acc_word = {16'h0000, phy_addr_ff, reg_idx_ff, 4'h0,
                     wr_not_rd_ff, mg_busy};
  assign wmerge_acc = merge(acc_word, wb_dat_i, wb_sel_i);

  // byte-merged write values
  assign wmerge_ahigh = merge(addr_high_ff, wb_dat_i, wb_sel_i);
  assign wmerge_data  = merge({16'h0000, data_ff}, wb_dat_i, wb_sel_i);

  // reserved bits read as zero
  always_comb begin
    rd_mux = `MAHP_RST_ZERO;
    if (hit_ahigh) begin
      rd_mux = {16'h0000, addr_high_ff[15:0]};
    end else if (hit_alow) begin
      rd_mux = addr_low_ff;
    end else if (hit_hhigh) begin
      rd_mux = hash_high_ff;
    end else if (hit_hlow) begin
      rd_mux = hash_low_ff;
    end else if (hit_acc) begin
      rd_mux = acc_word;
    end else if (hit_data) begin
      rd_mux = {16'h0000, data_ff};
    end else if (hit_ctrl) begin
      rd_mux[`MAHP_CTRL_PASS] = pass_all_ff;
      rd_mux[`MAHP_CTRL_INIT] = init_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: ack one cycle after the request, data with it
  // a new request needs an idle cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff  <= 1'b0;
      rdat_ff <= `MAHP_RST_ZERO;
    end else begin
      ack_ff  <= req && !ack_ff;
      rdat_ff <= (req && !ack_ff) ? rd_mux : rdat_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // initialisation flag
  // sticky until reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_ff <= 1'b0;
    end else if (ee_init_done) begin
      init_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // station address high
  // eeprom bytes first, host later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_high_ff <= `MAHP_RST_ADDR_HIGH;
    end else if (!init_ff && ee_byte_valid) begin
      if (ee_byte_loc == `MAHP_EE_HIGH_B0) begin
        addr_high_ff[7:0] <= ee_byte_data;
      end
      if (ee_byte_loc == `MAHP_EE_HIGH_B1) begin
        addr_high_ff[15:8] <= ee_byte_data;
      end
    end else if (init_ff && wr_edge && hit_ahigh) begin
      addr_high_ff <= {16'h0000,
                       wmerge_ahigh[15:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // station address low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_low_ff <= `MAHP_RST_ADDR_LOW;
    end else if (!init_ff && ee_byte_valid) begin
      if (ee_byte_loc == `MAHP_EE_LOW_B0) begin
        addr_low_ff[7:0] <= ee_byte_data;
      end
      if (ee_byte_loc == `MAHP_EE_LOW_B1) begin
        addr_low_ff[15:8] <= ee_byte_data;
      end
      if (ee_byte_loc == `MAHP_EE_LOW_B2) begin
        addr_low_ff[23:16] <= ee_byte_data;
      end
      if (ee_byte_loc == `MAHP_EE_LOW_B3) begin
        addr_low_ff[31:24] <= ee_byte_data;
      end
    end else if (init_ff && wr_edge && hit_alow) begin
      addr_low_ff <= merge(addr_low_ff, wb_dat_i, wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hash table words
  // writable at any time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hash_high_ff <= `MAHP_RST_ZERO;
      hash_low_ff  <= `MAHP_RST_ZERO;
    end else if (wr_edge) begin
      if (hit_hhigh) begin
        hash_high_ff <= merge(hash_high_ff, wb_dat_i, wb_sel_i);
      end
      if (hit_hlow) begin
        hash_low_ff <= merge(hash_low_ff, wb_dat_i, wb_sel_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pass_all_ff <= 1'b0;
    end else if (wr_edge && hit_ctrl && wb_sel_i[0]) begin
      pass_all_ff <= wb_dat_i[`MAHP_CTRL_PASS];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // management access register; writes while busy are dropped
  // fields latch on any idle write
  assign mg_start = wr_edge && hit_acc && !mg_busy && wb_sel_i[0] &&
                    wb_dat_i[`MAHP_ACC_BUSY];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_addr_ff  <= 5'h00;
      reg_idx_ff   <= 5'h00;
      wr_not_rd_ff <= 1'b0;
      phy_int_sel  <= 1'b0;
    end else if (wr_edge && hit_acc && !mg_busy) begin
      phy_addr_ff  <= wmerge_acc[`MAHP_ACC_PHY_MSB:`MAHP_ACC_PHY_LSB];
      reg_idx_ff   <= wmerge_acc[`MAHP_ACC_REG_MSB:`MAHP_ACC_REG_LSB];
      wr_not_rd_ff <= wmerge_acc[`MAHP_ACC_WR];
      phy_int_sel  <= (wmerge_acc[`MAHP_ACC_PHY_MSB:`MAHP_ACC_PHY_LSB] ==
                       `MAHP_INT_PHY_ADDR);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // management data register; frozen while busy
  // a read result beats a host write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= 16'h0000;
    end else if (mg_done && !wr_not_rd_ff) begin
      data_ff <= mg_rdata;
    end else if (wr_edge && hit_data && !mg_busy) begin
      data_ff <= wmerge_data[15:0];
    end
  end

  assign mdio_in = phy_int_sel ? mdio_int_i : mdio_ext_i;

  // fields come from the write
  mahp_mdio #(
    .HALF_CYC (HALF_CYC)
  ) u_mdio (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (mg_start),
    .wr       (wb_dat_i[`MAHP_ACC_WR]),
    .phy_addr (wmerge_acc[`MAHP_ACC_PHY_MSB:`MAHP_ACC_PHY_LSB]),
    .reg_addr (wmerge_acc[`MAHP_ACC_REG_MSB:`MAHP_ACC_REG_LSB]),
    .wdata    (data_ff),
    .busy     (mg_busy),
    .done     (mg_done),
    .rdata    (mg_rdata),
    .mdc      (mdc),
    .mdio_o   (mdio_o),
    .mdio_oe  (mdio_oe),
    .mdio_i   (mdio_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // multicast hash filter
  assign crc      = crc48(dst_addr);
  assign hash_idx = crc[31:26];
  assign hash_bit = hash_idx[5] ? hash_high_ff[hash_idx[4:0]]
                                : hash_low_ff[hash_idx[4:0]];
  // i/g bit marks a group address
  assign is_group = dst_addr[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grp_valid_ff  <= 1'b0;
      grp_accept_ff <= 1'b0;
    end else begin
      grp_valid_ff  <= dst_valid;
      grp_accept_ff <= dst_valid && is_group &&
                       (pass_all_ff || hash_bit);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // each straight from a flop
  assign wb_ack_o     = ack_ff;
  assign wb_dat_o     = rdat_ff;
  assign group_valid  = grp_valid_ff;
  assign group_accept = grp_accept_ff;
  assign station_addr = {addr_high_ff[15:0], addr_low_ff};
  assign init_done    = init_ff;
endmodule : mahp_top

/* sim/mahp_chk.sv */
// Purpose: port checker for mahp_top
// Assumes: one clock domain, rst_n async active low
// Notes:   bound to every mahp_top at the foot
`timescale 1ns/10ps
module mahp_chk #(
  parameter int ADR_W = 8,
  parameter int HALF_CYC = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire mahp_pkg::mahp_word_t wb_dat_o,
  input wire logic wb_ack_o,
  // loader and filter
  input wire logic ee_byte_valid,
  input wire logic [7:0] ee_byte_loc,
  input wire logic [7:0] ee_byte_data,
  input wire logic init_done,
  input wire logic dst_valid,
  input wire logic [47:0] dst_addr,
  input wire logic group_valid,
  input wire logic group_accept,
  input wire logic [47:0] station_addr,
  // management pins
  input wire logic mdc,
  input wire logic mdio_o
);
  import mahp_pkg::*;
  int hi_cnt_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////
  // cycles spent with mdc high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hi_cnt_ff <= 0;
    else if (mdc) hi_cnt_ff <= hi_cnt_ff + 1;
    else hi_cnt_ff <= 0;
  end
  //////////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack missing or too long");
  a_high_reserved: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h02
    |-> wb_dat_o[31:16] == 16'h0000)
    else $error("address high upper half not zero");
  a_ee_load: assert property (
    ee_byte_valid && !init_done && ee_byte_loc inside {[8'h01:8'h06]}
    |=> station_addr[($past(ee_byte_loc) - 8'h01) * 8 +: 8]
        == $past(ee_byte_data))
    else $error("eeprom byte in wrong place");
  a_addr_hold: assert property (
    !init_done && !ee_byte_valid |=> $stable(station_addr))
    else $error("station address moved before init");
  a_group_time: assert property (
    group_valid == $past(dst_valid))
    else $error("group result timing wrong");
  a_unicast_rej: assert property (
    dst_valid && !dst_addr[0] |=> !group_accept)
    else $error("individual address accepted");
  a_mdc_half: assert property (
    hi_cnt_ff <= HALF_CYC)
    else $error("mdc high too long");
  a_mdio_edge: assert property (
    $changed(mdio_o) |-> !mdc)
    else $error("mdio changed while mdc high");
  c_accept: cover property (group_accept);
  c_ee_load: cover property (ee_byte_valid && !init_done);
  c_frame: cover property ($fell(mdc));
endmodule : mahp_chk

bind mahp_top mahp_chk #(.ADR_W(ADR_W), .HALF_CYC(HALF_CYC)) u_chk (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .ee_byte_valid, .ee_byte_loc, .ee_byte_data, .init_done,
  .dst_valid, .dst_addr, .group_valid, .group_accept, .station_addr,
  .mdc, .mdio_o
);

/* sim/mahp_phy_model.sv */
// Purpose: behavioural PHY on the management pins
// Assumes: mdc made in the clk domain, idle mdc low
// Notes:   register i resets to {PHY_AD, 6'h2A, i}
`timescale 1ns/10ps
module mahp_phy_model #(
  parameter logic [4:0] PHY_AD = 5'h01
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // management pins
  input wire logic mdc,
  input wire logic mdio,
  output logic drv_o,
  output logic drv_oe
);
  logic [15:0] regs [32];
  logic [63:0] sh_ff;
  logic [6:0] cnt_ff;
  logic [3:0] idle_ff;
  logic mdc_ff;
  logic [1:0] op_ff;
  logic [4:0] reg_ff;
  logic hit_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) regs[i] <= {PHY_AD, 6'h2A, 5'(i)};
      {sh_ff, cnt_ff, idle_ff, mdc_ff, op_ff, reg_ff, hit_ff} <= '0;
      drv_o <= 1'b1;
      drv_oe <= 1'b0;
    end else begin
      mdc_ff <= mdc;
      idle_ff <= mdc ? 4'h0 : idle_ff + {3'h0, idle_ff != 4'hF};
      // frame over once mdc stands still
      if (idle_ff == 4'h8) {cnt_ff, hit_ff} <= '0;
      if (mdc && !mdc_ff) begin
        sh_ff <= {sh_ff[62:0], mdio};
        cnt_ff <= cnt_ff + 7'h01;
        if (cnt_ff == 7'd46) begin
          op_ff <= sh_ff[11:10];
          reg_ff <= sh_ff[4:0];
          hit_ff <= sh_ff[13:12] == 2'h1 && sh_ff[9:5] == PHY_AD;
        end
        if (cnt_ff == 7'd63 && hit_ff && op_ff == 2'h1)
          regs[reg_ff] <= {sh_ff[14:0], mdio};
      end
      // turnaround zero then data, msb first
      if (!mdc && mdc_ff) begin
        drv_oe <= hit_ff && op_ff == 2'h2 && cnt_ff >= 7'd47
                  && cnt_ff <= 7'd63;
        drv_o <= cnt_ff == 7'd47 ? 1'b0
                 : regs[reg_ff][4'(7'd63 - cnt_ff)];
      end
    end
  end
endmodule : mahp_phy_model

/* sim/mac_addr_hash_phy_mgmt_test.sv */
// Purpose: self-checking bench for mahp_top
// Assumes: HALF_CYC of 2, PHY models at 01 and 03
// Notes:   prints mismatches and the verdict only
`timescale 1ns/10ps
`include "mahp_defines.svh"
module mac_addr_hash_phy_mgmt_test;
  import mahp_pkg::*;
  localparam logic [7:0] A_HI = {`MAHP_IDX_ADDR_HIGH, 2'h0};
  localparam logic [7:0] A_LO = {`MAHP_IDX_ADDR_LOW, 2'h0};
  localparam logic [7:0] A_HH = {`MAHP_IDX_HASH_HIGH, 2'h0};
  localparam logic [7:0] A_HL = {`MAHP_IDX_HASH_LOW, 2'h0};
  localparam logic [7:0] A_ACC = {`MAHP_IDX_ACCESS, 2'h0};
  localparam logic [7:0] A_DAT = {`MAHP_IDX_DATA, 2'h0};
  localparam logic [7:0] A_CTL = {`MAHP_IDX_CTRL, 2'h0};
  logic clk = 1'b0, rst_n = 1'b0;
  logic cyc = 1'b0, we = 1'b0, ee_v = 1'b0, ee_done = 1'b0, dst_v = 1'b0;
  logic [7:0] adr = 8'h00, ee_loc = 8'h00, ee_d = 8'h00;
  logic [47:0] dst_a = 48'h0, sa;
  mahp_word_t wdat = 32'h0, rdat;
  logic ack, gv, ga, idn, mdc, mdo, mdoe, isel;
  logic int_o, int_oe, ext_o, ext_oe, mdio_int, mdio_ext;
  int err_total = 0;
  int cmp_count = 0;
  // pulled-up management line per PHY
  assign mdio_int = mdoe ? mdo : (int_oe ? int_o : 1'b1);
  assign mdio_ext = mdoe ? mdo : (ext_oe ? ext_o : 1'b1);
  always #2 clk = ~clk;
  mahp_top #(.HALF_CYC(2)) dut (
    .clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ee_byte_valid(ee_v), .ee_byte_loc(ee_loc),
    .ee_byte_data(ee_d), .ee_init_done(ee_done), .dst_valid(dst_v),
    .dst_addr(dst_a), .group_valid(gv), .group_accept(ga),
    .station_addr(sa), .init_done(idn), .mdc, .mdio_o(mdo),
    .mdio_oe(mdoe), .phy_int_sel(isel), .mdio_int_i(mdio_int),
    .mdio_ext_i(mdio_ext));
  mahp_phy_model #(.PHY_AD(5'h01)) u_int (.clk, .rst_n, .mdc,
    .mdio(mdio_int), .drv_o(int_o), .drv_oe(int_oe));
  mahp_phy_model #(.PHY_AD(5'h03)) u_ext (.clk, .rst_n, .mdc,
    .mdio(mdio_ext), .drv_o(ext_o), .drv_oe(ext_oe));
  //////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input mahp_word_t got, input mahp_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input mahp_word_t d, output mahp_word_t q);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      err_total++;
      $display("unexpected at %0t: no ack", $time);
      conclude;
    end
  endtask : wb
  task automatic rd_chk(input logic [7:0] a, input mahp_word_t e);
    mahp_word_t q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd_chk
  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    c = `MAHP_CRC_INIT;
    for (int i = 0; i < 48; i++)
      c = (c[0] ^ a[i]) ? (c >> 1) ^ `MAHP_CRC_POLY : c >> 1;
    return c[31:26];
  endfunction : hidx
  task automatic dst_chk(input logic [47:0] a, input logic e);
    dst_a <= a;
    dst_v <= 1'b1;
    @(posedge clk);
    dst_v <= 1'b0;
    @(posedge clk);
    chk({30'h0, gv, ga}, {30'h0, 1'b1, e});
  endtask : dst_chk
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    mahp_word_t q;
    rd_chk(A_HI, 32'h0000FFFF);
    rd_chk(A_LO, 32'h0FFFFFFF);
    rd_chk(A_HH, 32'h00000000);
    rd_chk(A_HL, 32'h00000000);
    rd_chk(A_ACC, 32'h00000000);
    rd_chk(8'h3C, 32'h00000000);
    wb(1'b1, A_LO, 32'h11223344, q);
    rd_chk(A_LO, 32'h0FFFFFFF);
  endtask : t_reset
  task automatic t_eeprom;
    logic [7:0] mac [6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC};
    mahp_word_t q;
    for (int i = 1; i <= 7; i++) begin
      ee_v <= 1'b1;
      ee_loc <= 8'(i);
      ee_d <= (i < 7) ? mac[i-1] : 8'hEE;
      @(posedge clk);
    end
    ee_v <= 1'b0;
    ee_done <= 1'b1;
    @(posedge clk);
    ee_done <= 1'b0;
    @(posedge clk);
    rd_chk(A_LO, 32'h78563412);
    rd_chk(A_HI, 32'h0000BC9A);
    wb(1'b1, A_HI, 32'hFFFF1234, q);
    rd_chk(A_HI, 32'h00001234);
  endtask : t_eeprom
  task automatic t_hash;
    logic [47:0] a;
    logic [63:0] oh;
    mahp_word_t q;
    for (int i = 0; i < 8; i++) begin
      a = {8'(i * 53), 32'h5E0000A0, 8'h01 | 8'(i << 1)};
      oh = 64'h1 << hidx(a);
      wb(1'b1, A_HH, oh[63:32], q);
      wb(1'b1, A_HL, oh[31:0], q);
      dst_chk(a, 1'b1);
      wb(1'b1, A_HH, ~oh[63:32], q);
      wb(1'b1, A_HL, ~oh[31:0], q);
      dst_chk(a, 1'b0);
      dst_chk(a & ~48'h1, 1'b0);
    end
    wb(1'b1, A_HH, 32'h0, q);
    wb(1'b1, A_HL, 32'h0, q);
    wb(1'b1, A_CTL, 32'h1, q);
    rd_chk(A_CTL, 32'h00000003);
    dst_chk(48'h0000000000A1, 1'b1);
    wb(1'b1, A_CTL, 32'h0, q);
    dst_chk(48'h0000000000A1, 1'b0);
  endtask : t_hash
  task automatic mgmt(input logic [4:0] p, input logic [4:0] r,
                      input logic w, input logic [15:0] d);
    mahp_word_t q;
    int n;
    n = 0;
    if (w) wb(1'b1, A_DAT, {16'h0, d}, q);
    wb(1'b1, A_ACC, {16'h0, p, r, 4'h0, w, 1'b1}, q);
    rd_chk(A_ACC, {16'h0, p, r, 4'h0, w, 1'b1});
    if (w) wb(1'b1, A_DAT, 32'h0000DEAD, q);
    do begin
      wb(1'b0, A_ACC, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    if (q[0] !== 1'b0) begin
      err_total++;
      $display("unexpected at %0t: busy stuck", $time);
      conclude;
    end
    chk(q, {16'h0, p, r, 4'h0, w, 1'b0});
    rd_chk(A_DAT, {16'h0, d});
  endtask : mgmt
  task automatic t_mgmt;
    mgmt(5'h01, 5'h05, 1'b1, 16'hA5C3);
    chk({16'h0, u_int.regs[5]}, 32'h0000A5C3);
    mgmt(5'h03, 5'h09, 1'b0, {5'h03, 6'h2A, 5'h09});
    mgmt(5'h01, 5'h05, 1'b0, 16'hA5C3);
  endtask : t_mgmt
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_eeprom;
    t_hash;
    t_mgmt;
    conclude;
  end
endmodule : mac_addr_hash_phy_mgmt_test
